//--- oh_far_end.sv
`timescale 1ns/100ps

module oh_far_end
  import t3_e3_oh_pkg::*;
(
  // Pins driven by the port
  input  wire logic      txClockPin,
  input  wire logic      txMarkPin,
  input  wire logic      rxClockPin,
  input  wire logic      rxDataPin,
  input  wire logic      rxMarkPin,
  input  wire ohInvert_t pinInvert,
  // Values the bench wants inserted
  input  wire logic      nextData,
  input  wire logic      nextEnable,
  // Pins driven by this model
  output logic           txDataPin,
  output logic           txEnablePin,
  // Activity counters
  output int             txTicks,
  output int             rxCount
);
  logic       txClk;
  logic       rxClk;
  logic       markSeen;
  logic [1:0] rxLog [0:255];

  // Undo the selected inversion before looking for edges
  assign txClk = txClockPin ^ pinInvert.txClock;
  assign rxClk = rxClockPin ^ pinInvert.rxClock;

  initial begin
    txDataPin = 1'b0;
    txEnablePin = 1'b0;
    markSeen = 1'b0;
    txTicks = 0;
    rxCount = 0;
  end

  // New values only at the rise, so they hold across the sampling fall
  always @(posedge txClk) begin
    txDataPin <= nextData ^ pinInvert.txData;
    txEnablePin <= nextEnable ^ pinInvert.txEnable;
    markSeen <= txMarkPin ^ pinInvert.txMark;
    txTicks <= txTicks + 1;
  end

  // Rise sees the bit presented at the previous fall
  always @(posedge rxClk) begin
    rxLog[rxCount[7:0]] <= {rxMarkPin ^ pinInvert.rxMark, rxDataPin ^ pinInvert.rxData};
    rxCount <= rxCount + 1;
  end
endmodule

//--- t3_e3_oh_pkg.sv
// Behaviour
// RULE1 - Overwrite framing bit where enable is active
// RULE2 - T3 sequence covers X, P, M, F, C
// RULE3 - G.751 sequence covers FAS, RAI, national bits
// RULE4 - G.832 sequence covers FA1..GC byte bits
// RULE5 - Transmit clock runs only in framing modes
// RULE6 - Sample data and enable on clock fall
// RULE7 - Update transmit mark on clock fall
// RULE8 - Outside logic acts on transmit clock rise
// RULE9 - Transmit mark flags first X/FAS/FA1 bit
// RULE10 - Transmit sequence starts at marked fall
// RULE11 - T3 receive outputs X, P, M, F, C
// RULE12 - M23 still presents C bits on receive
// RULE13 - E3 receive outputs all mode overhead bits
// RULE14 - Receive data and mark update on fall
// RULE15 - Outside logic samples receive on rise
// RULE16 - Every overhead pin separately invertible
// RULE17 - Overhead clocks tick only per overhead bit
// RULE18 - Receive mark flags first X/FAS/FA1 bit
// RULE19 - Receive sequence starts at marked fall
// RULE20 - Unenabled positions keep internal bit value
// RULE21 - Non-framing modes: inputs ignored, pins idle
package t3_e3_oh_pkg;

  // Port framing mode, anything unlisted behaves as unframed
  typedef enum logic [2:0] {
    MODE_UNFRAMED,
    MODE_T3_CBIT,
    MODE_T3_M23,
    MODE_E3_G751,
    MODE_E3_G832
  } frameMode_t;

  // One polarity select per overhead pin
  typedef struct packed {
    logic txData;
    logic txEnable;
    logic txClock;
    logic txMark;
    logic rxData;
    logic rxClock;
    logic rxMark;
  } ohInvert_t;

  // Transmit overhead position offered by the framer core
  typedef struct packed {
    logic first;
    logic cPos;
    logic internalBit;
  } txReq_t;

  // Receive line-side overhead strobe group
  typedef struct packed {
    logic first;
    logic cPos;
    logic pos;
    logic value;
  } rxLine_t;

  // Buffered receive overhead bit
  typedef struct packed {
    logic first;
    logic value;
  } ohBit_t;

  // Timing: each overhead clock phase lasts at least this long
  localparam int REF_PERIOD_NS = 20;
  localparam int OH_HALF_NS    = 100;
  localparam int OH_HALF_CYC   = (OH_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(OH_HALF_CYC - 1);

  // Receive buffer shape
  localparam int RX_FIFO_DEPTH = 32;
  localparam int RX_FIFO_WIDTH = $bits(ohBit_t);
  localparam int RX_SYNC_W     = $bits(rxLine_t) + 1;

endpackage

//--- t3_e3_overhead_port.sv
`timescale 1ns/100ps

module oh_bit_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty; depth must be a power of two
  assign outValid = (wrPtr_reg != rdPtr_reg);
  assign inReady  = !((wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                      (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]));
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_reg[AW-1:0]];

  // Storage, no reset needed on the data array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

module t3_e3_overhead_port
  import t3_e3_oh_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Configuration
  input  wire frameMode_t frameMode,
  input  wire ohInvert_t  pinInvert,
  // Transmit framer core side
  input  wire logic       txReqValid,
  output logic            txReqReady,
  input  wire txReq_t     txReq,
  output logic            txBitValid,
  output logic            txBitOut,
  // Transmit overhead pins
  input  wire logic       tx_overhead_data,
  input  wire logic       tx_overhead_overwrite_enable,
  output logic            tx_overhead_clock,
  output logic            tx_overhead_frame_mark,
  // Receive line side (line clock domain)
  input  wire logic       rxLineClock,
  input  wire rxLine_t    rxLine,
  output logic            rxLineReady,
  // Receive overhead pins
  output logic            rx_overhead_data,
  output logic            rx_overhead_clock,
  output logic            rx_overhead_frame_mark
);

  typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW} phase_t;

  logic             isFraming;
  logic             isT3;
  // Transmit state
  phase_t           txPhase_reg;
  logic [CNT_W-1:0] txCnt_reg;
  txReq_t           txHeld_reg;
  logic             txClkRaw_reg;
  logic             txMarkRaw_reg;
  logic [1:0]       txPinSync1_reg;
  logic [1:0]       txPinSync2_reg;
  logic             txDataIn;
  logic             txEnIn;
  logic             txOhBit;
  logic             txTake;
  logic             txFall;
  // Receive state
  logic [RX_SYNC_W-1:0] rxSync1_reg;
  logic [RX_SYNC_W-1:0] rxSync2_reg;
  logic                 rxClkPrev_reg;
  rxLine_t              rxLineS;
  logic                 rxRise;
  logic                 rxWant;
  logic                 rxWrValid;
  logic                 fifoInReady;
  logic                 fifoOutValid;
  ohBit_t               fifoOut;
  logic                 fifoPop;
  phase_t               rxPhase_reg;
  logic [CNT_W-1:0]     rxCnt_reg;
  logic                 rxClkRaw_reg;
  logic                 rxDataRaw_reg;
  logic                 rxMarkRaw_reg;
  logic                 rxFall;

  // Mode decode; unlisted codes fall to unframed
  assign isFraming = (frameMode == MODE_T3_CBIT) || (frameMode == MODE_T3_M23) ||
                     (frameMode == MODE_E3_G751) || (frameMode == MODE_E3_G832);
  assign isT3      = (frameMode == MODE_T3_CBIT) || (frameMode == MODE_T3_M23);

  // Pin inputs cross two flops before any logic sees them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txPinSync1_reg <= 2'h0;
      txPinSync2_reg <= 2'h0;
    end else begin
      txPinSync1_reg <= {tx_overhead_overwrite_enable, tx_overhead_data};
      txPinSync2_reg <= txPinSync1_reg;
    end
  end

  // Polarity undone after synchronisation
  assign txDataIn = txPinSync2_reg[0] ^ pinInvert.txData; // RULE16
  assign txEnIn   = txPinSync2_reg[1] ^ pinInvert.txEnable; // RULE16
  // Outside logic changes pins on our rise, a full phase before we sample
  assign txOhBit  = txEnIn ? txDataIn : txHeld_reg.internalBit; // RULE1 RULE20 RULE8

  // A position is taken only when the port is idle
  assign txTake = txReqValid && txReqReady;
  assign txFall = (txPhase_reg == PH_HIGH) && (txCnt_reg == HALF_LAST);

  // Transmit overhead clock sequencer: one clock cycle per overhead bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txPhase_reg   <= PH_IDLE;
      txCnt_reg     <= '0;
      txHeld_reg    <= '0;
      txClkRaw_reg  <= 1'b0;
      txMarkRaw_reg <= 1'b0;
    end else if (!isFraming) begin
      txPhase_reg   <= PH_IDLE; // RULE21
      txCnt_reg     <= '0;
      txClkRaw_reg  <= 1'b0; // RULE5
      txMarkRaw_reg <= 1'b0;
    end else begin
      unique case (txPhase_reg)
        PH_IDLE: begin
          // C positions are overhead only in the T3 modes
          if (txTake && (!txReq.cPos || isT3)) begin // RULE2 RULE3 RULE4
            txHeld_reg   <= txReq;
            txPhase_reg  <= PH_HIGH;
            txCnt_reg    <= '0;
            txClkRaw_reg <= 1'b1; // RULE17
          end
        end
        PH_HIGH: begin
          if (txFall) begin
            txPhase_reg   <= PH_LOW;
            txCnt_reg     <= '0;
            txClkRaw_reg  <= 1'b0; // RULE6
            txMarkRaw_reg <= txHeld_reg.first; // RULE7 RULE9 RULE10
          end else begin
            txCnt_reg <= txCnt_reg + 1'b1;
          end
        end
        PH_LOW: begin
          // Low phase held so the outside sees a full-width clock
          if (txCnt_reg == HALF_LAST) begin
            txPhase_reg <= PH_IDLE;
          end else begin
            txCnt_reg <= txCnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Handshake and result back to the framer core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txReqReady <= 1'b0;
      txBitValid <= 1'b0;
      txBitOut   <= 1'b0;
    end else begin
      txReqReady <= (txPhase_reg == PH_IDLE) && !txTake && !txReqReady;
      txBitValid <= 1'b0;
      if (txFall && isFraming) begin
        txBitValid <= 1'b1;
        txBitOut   <= txOhBit; // RULE1
      end else if (txTake && (!isFraming || (txReq.cPos && !isT3))) begin
        // Not an overhead position here: internal value passes untouched
        txBitValid <= 1'b1;
        txBitOut   <= txReq.internalBit; // RULE20 RULE21
      end
    end
  end

  // Line-side strobes and clock synchronised as one group
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSync1_reg   <= '0;
      rxSync2_reg   <= '0;
      rxClkPrev_reg <= 1'b0;
    end else begin
      rxSync1_reg   <= {rxLineClock, rxLine};
      rxSync2_reg   <= rxSync1_reg;
      rxClkPrev_reg <= rxSync2_reg[RX_SYNC_W-1];
    end
  end

  // Strobes are stable around the line clock rise, so sample there
  assign rxLineS   = rxSync2_reg[RX_SYNC_W-2:0];
  assign rxRise    = rxSync2_reg[RX_SYNC_W-1] && !rxClkPrev_reg;
  // M23 still hands C bits to the overhead port
  assign rxWant    = rxLineS.pos || (rxLineS.cPos && isT3); // RULE11 RULE12 RULE13
  assign rxWrValid = isFraming && rxRise && rxWant;

  // Buffer absorbs bursts between line rate and the slow overhead clock
  oh_bit_fifo #(
    .WIDTH (RX_FIFO_WIDTH),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .flush    (!isFraming),
    .inValid  (rxWrValid),
    .inReady  (fifoInReady),
    .inData   ({rxLineS.first, rxLineS.value}),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOut)
  );

  // Pop at the start of each receive clock cycle
  assign fifoPop = isFraming && (rxPhase_reg == PH_IDLE) && fifoOutValid;
  assign rxFall  = (rxPhase_reg == PH_HIGH) && (rxCnt_reg == HALF_LAST);

  ohBit_t rxHeld_reg;

  // Receive overhead clock sequencer, stalls while the buffer is empty
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxPhase_reg   <= PH_IDLE;
      rxCnt_reg     <= '0;
      rxHeld_reg    <= '0;
      rxClkRaw_reg  <= 1'b0;
      rxDataRaw_reg <= 1'b0;
      rxMarkRaw_reg <= 1'b0;
    end else if (!isFraming) begin
      rxPhase_reg   <= PH_IDLE;
      rxCnt_reg     <= '0;
      rxClkRaw_reg  <= 1'b0; // RULE21
      rxDataRaw_reg <= 1'b0;
      rxMarkRaw_reg <= 1'b0;
    end else begin
      unique case (rxPhase_reg)
        PH_IDLE: begin
          if (fifoPop) begin
            rxHeld_reg   <= fifoOut;
            rxPhase_reg  <= PH_HIGH;
            rxCnt_reg    <= '0;
            rxClkRaw_reg <= 1'b1; // RULE17 RULE15
          end
        end
        PH_HIGH: begin
          if (rxFall) begin
            rxPhase_reg   <= PH_LOW;
            rxCnt_reg     <= '0;
            rxClkRaw_reg  <= 1'b0;
            rxDataRaw_reg <= rxHeld_reg.value; // RULE14
            rxMarkRaw_reg <= rxHeld_reg.first; // RULE18 RULE19
          end else begin
            rxCnt_reg <= rxCnt_reg + 1'b1;
          end
        end
        PH_LOW: begin
          if (rxCnt_reg == HALF_LAST) begin
            rxPhase_reg <= PH_IDLE;
          end else begin
            rxCnt_reg <= rxCnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Pin drivers with per-pin polarity; one cycle behind the raw state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_overhead_clock      <= 1'b0;
      tx_overhead_frame_mark <= 1'b0;
      rx_overhead_clock      <= 1'b0;
      rx_overhead_data       <= 1'b0;
      rx_overhead_frame_mark <= 1'b0;
      rxLineReady            <= 1'b0;
    end else begin
      tx_overhead_clock      <= txClkRaw_reg ^ pinInvert.txClock; // RULE16
      tx_overhead_frame_mark <= txMarkRaw_reg ^ pinInvert.txMark; // RULE16
      rx_overhead_clock      <= rxClkRaw_reg ^ pinInvert.rxClock; // RULE16
      rx_overhead_data       <= rxDataRaw_reg ^ pinInvert.rxData; // RULE16
      rx_overhead_frame_mark <= rxMarkRaw_reg ^ pinInvert.rxMark; // RULE16
      rxLineReady            <= fifoInReady && isFraming;
    end
  end

  // Checks
  a_tx_idle_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE21
    !isFraming |=> (!txClkRaw_reg && !rxClkRaw_reg && !txMarkRaw_reg))
    else $error("overhead clocks active outside framing mode");

  a_tx_fall_sample: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
    (txFall && isFraming) |=> (txBitValid && txBitOut == $past(txOhBit) && !txClkRaw_reg))
    else $error("transmit bit not taken at clock fall");

  a_tx_mark_fall: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
    (txFall && isFraming) |=> (txMarkRaw_reg == $past(txHeld_reg.first)))
    else $error("transmit mark not updated at clock fall");

  a_tx_keep_internal: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE20
    (txFall && isFraming && !txEnIn) |=> (txBitOut == $past(txHeld_reg.internalBit)))
    else $error("internal bit lost without overwrite enable");

  a_tx_clk_width: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
    ($rose(txClkRaw_reg) && isFraming) |-> txClkRaw_reg[*5])
    else $error("transmit clock high phase too short");

  a_rx_c_bits: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
    (rxRise && frameMode == MODE_T3_M23 && rxLineS.cPos) |-> rxWrValid)
    else $error("M23 C bit not forwarded");

  a_rx_fall_update: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
    (rxFall && isFraming) |=> (!rxClkRaw_reg && rxDataRaw_reg == $past(rxHeld_reg.value)
      && rxMarkRaw_reg == $past(rxHeld_reg.first)))
    else $error("receive outputs not updated at clock fall");

  a_rx_clk_width: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
    ($rose(rxClkRaw_reg) && isFraming) |-> ##1 rxClkRaw_reg[*4] ##1 !rxClkRaw_reg)
    else $error("receive clock high phase wrong width");

  a_pin_invert: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE16
    1'b1 |=> (rx_overhead_data == ($past(rxDataRaw_reg) ^ $past(pinInvert.rxData))))
    else $error("receive data polarity wrong");

endmodule

//--- tb.sv
`timescale 1ns/100ps

module tb;
  import t3_e3_oh_pkg::*;

  typedef struct packed {
    frameMode_t mode;
    logic [6:0] bits;
  } txRow_t;

  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  frameMode_t frameMode = MODE_UNFRAMED;
  ohInvert_t  pinInvert = '0;
  logic       txReqValid = 1'b0;
  txReq_t     txReq = '0;
  logic       rxLineClock = 1'b0;
  rxLine_t    rxLine = '0;
  logic       nextData = 1'b0;
  logic       nextEnable = 1'b0;
  logic       txReqReady, txBitValid, txBitOut, txDataPin, txEnablePin;
  logic       txClkPin, txMarkPin, rxLineReady, rxDataPin, rxClkPin, rxMarkPin;
  logic       lowSeen;
  int         txTicks, rxCount, c0;
  int         n_errors = 0;
  int         tests_run = 0;

  // Bits: first, cPos, internalBit, data, enable, expected bit, expected ticks
  txRow_t txRows [8] = '{
    '{MODE_T3_CBIT, 7'b1001111},          // Overwrite marked first bit
    '{MODE_T3_CBIT, 7'b0010011},          // Enable off keeps core bit
    '{MODE_T3_M23, 7'b0101111},           // C position counts in T3
    '{MODE_E3_G751, 7'b1010101},
    '{MODE_E3_G832, 7'b1001111},
    '{MODE_E3_G832, 7'b0110110},          // C position passes in E3
    '{MODE_UNFRAMED, 7'b0010110},         // Inputs ignored
    '{frameMode_t'(3'h7), 7'b0001100}     // Unlisted code
  };

  always #10 ref_clk = ~ref_clk;

  t3_e3_overhead_port i_t3_e3_overhead_port (
    .ref_clk(ref_clk), .rst_n(rst_n), .frameMode(frameMode), .pinInvert(pinInvert),
    .txReqValid(txReqValid), .txReqReady(txReqReady), .txReq(txReq),
    .txBitValid(txBitValid), .txBitOut(txBitOut), .tx_overhead_data(txDataPin),
    .tx_overhead_overwrite_enable(txEnablePin), .tx_overhead_clock(txClkPin),
    .tx_overhead_frame_mark(txMarkPin), .rxLineClock(rxLineClock), .rxLine(rxLine),
    .rxLineReady(rxLineReady), .rx_overhead_data(rxDataPin),
    .rx_overhead_clock(rxClkPin), .rx_overhead_frame_mark(rxMarkPin));

  oh_far_end i_oh_far_end (
    .txClockPin(txClkPin), .txMarkPin(txMarkPin), .rxClockPin(rxClkPin),
    .rxDataPin(rxDataPin), .rxMarkPin(rxMarkPin), .pinInvert(pinInvert),
    .nextData(nextData), .nextEnable(nextEnable), .txDataPin(txDataPin),
    .txEnablePin(txEnablePin), .txTicks(txTicks), .rxCount(rxCount));

  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One overhead request; far end inserts its values at the clock rise
  task automatic tx_one(input txRow_t r);
    int   t0;
    logic seen;
    frameMode = r.mode;
    {txReq, nextData, nextEnable} = r.bits[6:2];
    t0 = txTicks;
    txReqValid = 1'b1;
    seen = 1'b0;
    for (int k = 0; k < 40 && !seen; k++) begin
      seen = (txReqReady === 1'b1);
      @(negedge ref_clk);
    end
    txReqValid = 1'b0;
    seen = 1'b0;
    // A pass-through answer stands only in the cycle right after the take
    for (int k = 0; k < 40 && !seen; k++) begin
      seen = (txBitValid === 1'b1);
      if (!seen) @(negedge ref_clk);
    end
    check_bit("txBitOut", r.bits[1], seen ? txBitOut : 1'bx);
    @(negedge ref_clk);
    if (r.bits[0]) check_bit("txMark", r.bits[6], txMarkPin ^ pinInvert.txMark);
    repeat (8) @(negedge ref_clk);
    check_count("txTicks", r.bits[0], txTicks - t0);
  endtask

  // Line bit; link clock idles low, every change lands on a ref fall
  task automatic line_bit(input rxLine_t b);
    rxLine = b;
    #60 rxLineClock = 1'b1;
    #80 rxLineClock = 1'b0;
    #20;
  endtask

  // First, idle, C position, plain bit, then a trailer that flushes the last
  task automatic rx_seq(input frameMode_t m, input int expN, input logic [2:0] expV);
    frameMode = m;
    c0 = rxCount;
    line_bit(4'b1011);
    line_bit(4'b0000);
    line_bit(4'b0100);
    line_bit(4'b0011);
    line_bit(4'b0010);
    rxLine = ~rxLine;
    repeat (60) @(negedge ref_clk);
    check_count("rxBits", expN, rxCount - c0);
    for (int k = 1; k < expN; k++) begin
      check_bit("rxMark", k == 1, i_oh_far_end.rxLog[c0 + k][1]);
      check_bit("rxData", expV[3 - k], i_oh_far_end.rxLog[c0 + k][0]);
    end
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      tx_one(txRows[i]);
    end
    rx_seq(MODE_T3_CBIT, 4, 3'b101);
    rx_seq(MODE_T3_M23, 4, 3'b101);
    rx_seq(MODE_E3_G751, 3, 3'b110);
    rx_seq(MODE_E3_G832, 3, 3'b110);
    rx_seq(MODE_UNFRAMED, 0, 3'b000);
    // Second reset in mid-run, every pin inverted
    rst_n = 1'b0;
    pinInvert = '1;
    @(negedge ref_clk);
    check_bit("rstTxClock", 1'b0, txClkPin);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_bit("idleTxClock", 1'b1, txClkPin);
    check_bit("idleRxClock", 1'b1, rxClkPin);
    tx_one(txRows[3]);
    rx_seq(MODE_T3_CBIT, 4, 3'b101);
    // Line rate outruns the overhead clock, so the buffer must fill and drop
    c0 = rxCount;
    lowSeen = 1'b0;
    for (int k = 0; k < 140; k++) begin
      line_bit({k == 0, 1'b0, 1'b1, k[0] ^ k[2]});
      if (rxLineReady === 1'b0) lowSeen = 1'b1;
    end
    rxLine = ~rxLine;
    repeat (450) @(negedge ref_clk);
    check_bit("rxLineReadyLow", 1'b1, lowSeen);
    check_count("rxDropped", 1, int'(rxCount - c0 < 140));
    for (int k = 0; k < 24; k++) begin
      check_bit("burstData", k[0] ^ k[2], i_oh_far_end.rxLog[c0 + 1 + k][0]);
    end
    final_report();
  end

  // Whole run is a few thousand cycles; this cuts a hang short
  initial begin
    #200000;
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    final_report();
  end
endmodule
